/* File: hw/sdci_burst.sv */
// beat counter: two beats per clock, eight or four per access
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.svh"
module sdci_burst
(
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  sdci_burst_if.dst   bif
);
  logic [3:0] left_ff;
  logic [3:0] nxt_left;
  assign nxt_left = bif.start ? bif.len
                  : (left_ff != 4'h0) ? left_ff - 4'h2 : 4'h0;
  assign bif.busy = (left_ff != 4'h0);
  assign bif.beat = bif.busy;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      left_ff <= 4'h0;
    else
      left_ff <= nxt_left;
  end
  chk_burst_len_full: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bif.start && bif.len == `SDCI_BURST_FULL |=> bif.busy [*4] ##1 !bif.busy)
    else $error("full burst not four clocks");
endmodule // sdci_burst
`default_nettype wire

/* File: hw/sdci_burst_if.sv */
// burst request between decoder and beat counter
`timescale 1ns/1ps
`default_nettype none
interface sdci_burst_if;
  logic       start;
  logic [3:0] len;
  logic       busy;
  logic       beat;
  modport src (output start, output len, input busy, input beat);
  modport dst (input start, input len, output busy, output beat);
endinterface
`default_nettype wire

/* File: hw/sdci_core.sv */
// sdram command decode, init tracking and mode register defaults
// Contract
// - byte-wide part: sixteen banks, four groups
// - sixteen-bit part: eight banks, two groups
// - eight-word prefetch, two words per clock
// - bursts of eight or chopped four
// - activate latches group, bank, row bits
// - read/write take column; bit ten precharge
// - bit twelve picks chop when enabled
// - mode three defaults: gear-down, addressability zero
// - mode four defaults: power, latency, repairs zero
// - mode five parity latency resets zero
// - device recognises the full command set
`timescale 1ns/1ps
`default_nettype none
`include "sdci_defines.svh"
module sdci_core
  import sdci_pkg::*;
#(
  parameter int RESET_WAIT_CYC = `SDCI_RESET_WAIT_CYC
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              x16_mode_i,
  input  wire logic              ck_en_i,
  input  wire logic              boundary_scan_enable_i,
  input  wire sdci_pkg::sdci_cmd_t cmd_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [1:0]        bank_group_sel_i,
  input  wire logic [1:0]        bank_i,
  input  wire logic [17:0]       addr_i,
  output logic                   init_done_o,
  output logic                   cmd_err_o,
  output logic [1:0]             act_group_o,
  output logic [1:0]             act_bank_o,
  output logic [17:0]            act_row_o,
  output logic [17:0]            col_o,
  output logic                   auto_precharge_o,
  output logic                   chopped_burst_four_o,
  output logic                   burst_active_o,
  output logic                   rd_o,
  output logic                   wr_o,
  output logic [4:0]             bank_count_o,
  output logic [17:0]            mode_register_three_o,
  output logic [17:0]            mode_register_four_o,
  output logic [17:0]            mode_register_five_o
);
  import sdci_pkg::*;

  typedef enum logic [2:0] {
    SDCI_ST_RESET, SDCI_ST_WAIT_CKE, SDCI_ST_XPR, SDCI_ST_MRS,
    SDCI_ST_CAL, SDCI_ST_IDLE
  } sdci_state_t;

  // three-stage pin synchronisers for clock enable and scan enable
  logic [2:0] cke_sync_ff;
  logic [2:0] ten_sync_ff;
  logic       cke_ff;
  logic       ten_ff;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cke_sync_ff <= 3'h0;
      ten_sync_ff <= 3'h0;
      cke_ff      <= 1'b0;
      ten_ff      <= 1'b0;
    end
    else
    begin
      cke_sync_ff <= {cke_sync_ff[1:0], ck_en_i};
      ten_sync_ff <= {ten_sync_ff[1:0], boundary_scan_enable_i};
      if (cke_sync_ff[1] == cke_sync_ff[2])
        cke_ff <= cke_sync_ff[2];
      if (ten_sync_ff[1] == ten_sync_ff[2])
        ten_ff <= ten_sync_ff[2];
    end
  end

  sdci_state_t st_ff;
  sdci_state_t nxt_st;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        otf_en_ff;
  logic        idle_w;
  logic        is_act_w;
  logic        is_rd_w;
  logic        is_wr_w;
  logic        is_mrs_w;
  logic        is_array_w;
  logic        is_known_w;
  logic        chop_w;
  logic [1:0]  grp_w;
  logic [2:0]  mr_idx_w;

  assign idle_w     = (st_ff == SDCI_ST_IDLE);
  assign is_act_w   = cmd_valid_i && cmd_i == SDCI_CMD_ACT;
  assign is_rd_w    = cmd_valid_i && (cmd_i == SDCI_CMD_RD
                      || cmd_i == SDCI_CMD_RDA);
  assign is_wr_w    = cmd_valid_i && (cmd_i == SDCI_CMD_WR
                      || cmd_i == SDCI_CMD_WRA);
  assign is_mrs_w   = cmd_valid_i && cmd_i == SDCI_CMD_MRS;
  assign is_known_w = cmd_i < SDCI_CMD_BAD;
  assign is_array_w = is_act_w || is_rd_w || is_wr_w || (cmd_valid_i &&
                      (cmd_i == SDCI_CMD_PRE || cmd_i == SDCI_CMD_PREA ||
                       cmd_i == SDCI_CMD_REF));
  // x16 uses only the low group bit
  assign grp_w      = x16_mode_i ? {1'b0, bank_group_sel_i[0]}
                                 : bank_group_sel_i;
  assign chop_w     = otf_en_ff && !addr_i[`SDCI_BC_BIT];
  assign mr_idx_w   = {bank_group_sel_i[0], bank_i};

  // init sequence tracking
  always_comb
  begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff + 32'h1;
    case (st_ff)
      SDCI_ST_RESET:
        if (cnt_ff >= 32'(RESET_WAIT_CYC - 1))
        begin
          nxt_st  = SDCI_ST_WAIT_CKE;
          nxt_cnt = 32'h0;
        end
      SDCI_ST_WAIT_CKE:
        if (cke_ff)
        begin
          nxt_st  = SDCI_ST_XPR;
          nxt_cnt = 32'h0;
        end
      SDCI_ST_XPR:
        if (cnt_ff >= 32'(`SDCI_XPR_CLKS - 1))
        begin
          nxt_st  = SDCI_ST_MRS;
          nxt_cnt = 32'h0;
        end
      SDCI_ST_MRS:
        if (cmd_valid_i && cmd_i == SDCI_CMD_ZQCL)
        begin
          nxt_st  = SDCI_ST_CAL;
          nxt_cnt = 32'h0;
        end
      SDCI_ST_CAL:
        if (cnt_ff >= 32'(`SDCI_INIT_DONE_CYC - 1))
          nxt_st = SDCI_ST_IDLE;
      default:
        nxt_cnt = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_ff  <= SDCI_ST_RESET;
      cnt_ff <= 32'h0;
    end
    else
    begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // burst beat counter
  sdci_burst_if bif ();
  logic rw_ok_w;
  assign rw_ok_w   = idle_w && (is_rd_w || is_wr_w) && !bif.busy;
  assign bif.start = rw_ok_w;
  assign bif.len   = chop_w ? `SDCI_BURST_CHOP : `SDCI_BURST_FULL;
  sdci_burst u_burst
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bif       (bif)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      init_done_o          <= 1'b0;
      cmd_err_o            <= 1'b0;
      act_group_o          <= 2'h0;
      act_bank_o           <= 2'h0;
      act_row_o            <= 18'h0;
      col_o                <= 18'h0;
      auto_precharge_o     <= 1'b0;
      chopped_burst_four_o <= 1'b0;
      burst_active_o       <= 1'b0;
      rd_o                 <= 1'b0;
      wr_o                 <= 1'b0;
      bank_count_o         <= `SDCI_BANKS_X8;
      otf_en_ff            <= 1'b0;
      mode_register_three_o <= `SDCI_MR_RESET;
      mode_register_four_o  <= `SDCI_MR_RESET;
      mode_register_five_o  <= `SDCI_MR_RESET;
    end
    else
    begin
      init_done_o    <= idle_w;
      burst_active_o <= bif.busy || rw_ok_w;
      rd_o           <= rw_ok_w && is_rd_w;
      wr_o           <= rw_ok_w && is_wr_w;
      bank_count_o   <= x16_mode_i ? `SDCI_BANKS_X16 : `SDCI_BANKS_X8;
      cmd_err_o      <= cmd_valid_i && (!is_known_w || ten_ff
                        || (is_array_w && !idle_w));
      if (is_act_w && idle_w)
      begin
        act_group_o <= grp_w;
        act_bank_o  <= bank_i;
        act_row_o   <= addr_i;
      end
      if (rw_ok_w)
      begin
        col_o                <= addr_i;
        auto_precharge_o     <= addr_i[`SDCI_AP_BIT];
        chopped_burst_four_o <= chop_w;
      end
      if (is_mrs_w && (st_ff == SDCI_ST_MRS || idle_w))
      begin
        case (mr_idx_w)
          `SDCI_MR_IDX_THREE: mode_register_three_o <= addr_i;
          `SDCI_MR_IDX_FOUR:  mode_register_four_o  <= addr_i;
          `SDCI_MR_IDX_FIVE:  mode_register_five_o  <= addr_i;
          `SDCI_MR_IDX_ZERO:  otf_en_ff <= addr_i[`SDCI_MR_OTF_BIT];
          default:            otf_en_ff <= otf_en_ff;
        endcase
      end
    end
  end

  chk_rw_needs_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !idle_w && is_rd_w |=> !rd_o)
    else $error("read taken before init done");
  chk_mr_defaults: assert property (@(posedge sys_clk_i)
    $past(rst_i) && !rst_i |-> mode_register_five_o == `SDCI_MR_RESET
      && mode_register_three_o == `SDCI_MR_RESET)
    else $error("mode register default wrong");
  chk_mr4_default: assert property (@(posedge sys_clk_i)
    $past(rst_i) && !rst_i |-> mode_register_four_o == `SDCI_MR_RESET)
    else $error("mode four default wrong");
  chk_ap_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rw_ok_w |=> auto_precharge_o == $past(addr_i[`SDCI_AP_BIT]))
    else $error("auto precharge not latched");
  chk_chop_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rw_ok_w && !otf_en_ff |=> !chopped_burst_four_o)
    else $error("chop without otf enable");
  chk_x16_group: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    is_act_w && idle_w && x16_mode_i |=> !act_group_o[1])
    else $error("x16 group high bit set");
  chk_bank_cnt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    x16_mode_i ##1 x16_mode_i |-> bank_count_o == `SDCI_BANKS_X16)
    else $error("x16 bank count wrong");
  chk_bank_cnt8: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !x16_mode_i ##1 !x16_mode_i |-> bank_count_o == `SDCI_BANKS_X8)
    else $error("x8 bank count wrong");
  chk_burst_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rw_ok_w |=> burst_active_o)
    else $error("burst not flagged");

  // accepted burst as seen at the outputs, step by step
  sequence s_full_accept;
    rw_ok_w && !chop_w;
  endsequence
  sequence s_chop_accept;
    rw_ok_w && chop_w;
  endsequence
  // a burst ends unless the next one is taken on its last beat
  sequence s_burst_tail;
    !burst_active_o || rd_o || wr_o;
  endsequence
  chk_full_span: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_full_accept |=> burst_active_o [*5] ##1 s_burst_tail)
    else $error("full burst span wrong");
  chk_chop_span: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_chop_accept |=> burst_active_o [*3] ##1 s_burst_tail)
    else $error("chopped burst span wrong");
  chk_rw_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rw_ok_w |-> ##2 (!rd_o && !wr_o))
    else $error("read or write pulse too long");
  chk_early_err: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !idle_w && is_array_w |=> cmd_err_o)
    else $error("early array command not flagged");
  chk_col_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rw_ok_w |=> col_o == $past(addr_i))
    else $error("column not latched");
  chk_act_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    is_act_w && idle_w |=> act_row_o == $past(addr_i)
      && act_bank_o == $past(bank_i))
    else $error("row or bank not latched");
endmodule // sdci_core
`default_nettype wire

/* File: hw/sdci_defines.svh */
// constants for the sdram command front end and init tracker
`ifndef SDCI_DEFINES_SVH
`define SDCI_DEFINES_SVH
`define SDCI_CLK_MHZ          100
`define SDCI_RESET_WAIT_US    500
`define SDCI_RESET_WAIT_CYC   (`SDCI_RESET_WAIT_US * `SDCI_CLK_MHZ)
`define SDCI_XPR_CLKS         5
`define SDCI_INIT_DONE_CYC    16'h0200
`define SDCI_AP_BIT           10
`define SDCI_BC_BIT           12
`define SDCI_MR3_GEARDOWN     3
`define SDCI_MR3_PDA          4
`define SDCI_MR4_MAXPS        1
`define SDCI_MR4_SOFT_ROW_REPAIR         5
`define SDCI_MR4_CAL_LO       6
`define SDCI_MR4_HARD_ROW_REPAIR         13
`define SDCI_MR5_PAR_LO       0
`define SDCI_MR_OTF_BIT       0
`define SDCI_MR_IDX_THREE     3'h3
`define SDCI_MR_IDX_FOUR      3'h4
`define SDCI_MR_IDX_FIVE      3'h5
`define SDCI_MR_IDX_ZERO      3'h0
`define SDCI_MR_IDX_ONE       3'h1
`define SDCI_MR_RESET         18'h00000
`define SDCI_BURST_FULL       4'h8
`define SDCI_BURST_CHOP       4'h4
`define SDCI_BANKS_X8         5'h10
`define SDCI_BANKS_X16        5'h08
`endif

/* File: hw/sdci_pkg.sv */
// types shared by the sdram command front end
`default_nettype none
package sdci_pkg;
  typedef enum logic [4:0] {
    SDCI_CMD_DES, SDCI_CMD_NOP, SDCI_CMD_ACT, SDCI_CMD_PRE, SDCI_CMD_PREA,
    SDCI_CMD_RD, SDCI_CMD_RDA, SDCI_CMD_WR, SDCI_CMD_WRA, SDCI_CMD_REF,
    SDCI_CMD_SRE, SDCI_CMD_SRX, SDCI_CMD_PDE, SDCI_CMD_PDX, SDCI_CMD_MRS,
    SDCI_CMD_MPR, SDCI_CMD_ZQCL, SDCI_CMD_ZQCS, SDCI_CMD_TEN, SDCI_CMD_BAD
  } sdci_cmd_t;
endpackage
`default_nettype wire

/* File: verif/sdci_host_model.sv */
// host controller model: init sequence and command issue
`timescale 1ns/1ps
`default_nettype none
module sdci_host_model
#(
  parameter int WAIT_CYC = 25
)
(
  input  wire logic                sys_clk_i,
  input  wire logic                init_done_i,
  output var  logic                ck_en_o,
  output var  sdci_pkg::sdci_cmd_t cmd_o,
  output var  logic                cmd_valid_o,
  output var  logic [1:0]          bank_group_sel_o,
  output var  logic [1:0]          bank_o,
  output var  logic [17:0]         addr_o
);
  import sdci_pkg::*;
  logic [2:0]  mr_order [7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  logic [17:0] mr_val   [8] = '{18'h00001, 18'h00000, 18'h00000, 18'h00008,
                                18'h02040, 18'h00005, 18'h00000, 18'h00000};
  initial
  begin
    ck_en_o          = 1'b0;
    cmd_o            = SDCI_CMD_DES;
    cmd_valid_o      = 1'b0;
    bank_group_sel_o = 2'h0;
    bank_o           = 2'h0;
    addr_o           = 18'h00000;
  end
  // one command, then deselect; never a no-op here
  task automatic issue(input sdci_cmd_t c, input logic [1:0] g,
                       input logic [1:0] b, input logic [17:0] a);
    @(negedge sys_clk_i);
    cmd_o            = c;
    cmd_valid_o      = 1'b1;
    bank_group_sel_o = g;
    bank_o           = b;
    addr_o           = a;
    @(negedge sys_clk_i);
    cmd_o            = SDCI_CMD_DES;
    cmd_valid_o      = 1'b0;
    addr_o           = ~a;
  endtask
  task automatic hold_low;
    ck_en_o = 1'b0;
  endtask
  task automatic init_seq(output logic ok);
    int i;
    ok = 1'b0;
    repeat (WAIT_CYC) @(negedge sys_clk_i);
    ck_en_o = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    for (i = 0; i < 7; i++)
    begin
      issue(SDCI_CMD_MRS, {1'b0, mr_order[i][2]}, mr_order[i][1:0],
            mr_val[mr_order[i]]);
      repeat (2) @(negedge sys_clk_i);
    end
    issue(SDCI_CMD_ZQCL, 2'h0, 2'h0, 18'h00000);
    for (i = 0; i < 700 && ok !== 1'b1; i++)
    begin
      @(negedge sys_clk_i);
      ok = init_done_i;
    end
  endtask
endmodule // sdci_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the sdram command front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module testbench;
  import sdci_pkg::*;
  typedef struct packed {
    sdci_cmd_t   cmd;
    logic        x16;
    logic [1:0]  grp;
    logic [1:0]  bnk;
    logic [17:0] adr;
  } sdci_row_t;
  sdci_row_t rows [6] = '{
    '{SDCI_CMD_ACT, 1'b0, 2'h3, 2'h2, 18'h3FFFF},
    '{SDCI_CMD_RD,  1'b0, 2'h3, 2'h2, 18'h00400},
    '{SDCI_CMD_WR,  1'b0, 2'h3, 2'h2, 18'h01007},
    '{SDCI_CMD_ACT, 1'b1, 2'h3, 2'h1, 18'h12345},
    '{SDCI_CMD_WRA, 1'b1, 2'h1, 2'h1, 18'h01400},
    '{SDCI_CMD_RDA, 1'b1, 2'h1, 2'h1, 18'h3F7FF}};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        x16_mode = 1'b0;
  logic        scan_en = 1'b0;
  wire logic   ck_en;
  sdci_cmd_t   cmd;
  wire logic   cmd_valid;
  wire logic [1:0] grp_sel;
  wire logic [1:0] bank;
  wire logic [17:0] addr;
  logic        init_done, cmd_err, auto_pre, chop, burst_active, rd, wr;
  logic [1:0]  act_group, act_bank;
  logic [17:0] act_row, col, mr_three, mr_four, mr_five;
  logic [4:0]  bank_count;
  sdci_row_t   r;
  logic        ok, is_rd, is_wr;
  logic        e_ap = 1'b0, e_chop = 1'b0;
  logic [1:0]  e_grp, e_bnk;
  logic [17:0] e_row, e_col = 18'h0;
  int          err_count = 0, n_checks = 0, cyc = 0;
  int          n_rd, n_wr, n_busy, n_err;
  sdci_core #(.RESET_WAIT_CYC(20)) dut_u (.sys_clk_i(sys_clk), .rst_i(rst),
    .x16_mode_i(x16_mode), .ck_en_i(ck_en), .boundary_scan_enable_i(scan_en),
    .cmd_i(cmd), .cmd_valid_i(cmd_valid), .bank_group_sel_i(grp_sel),
    .bank_i(bank), .addr_i(addr), .init_done_o(init_done),
    .cmd_err_o(cmd_err), .act_group_o(act_group), .act_bank_o(act_bank),
    .act_row_o(act_row), .col_o(col), .auto_precharge_o(auto_pre),
    .chopped_burst_four_o(chop), .burst_active_o(burst_active), .rd_o(rd),
    .wr_o(wr), .bank_count_o(bank_count), .mode_register_three_o(mr_three),
    .mode_register_four_o(mr_four), .mode_register_five_o(mr_five));
  sdci_host_model host_u (.sys_clk_i(sys_clk), .init_done_i(init_done),
    .ck_en_o(ck_en), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
    .bank_group_sel_o(grp_sel), .bank_o(bank), .addr_o(addr));
  always #5 sys_clk = ~sys_clk;
  task automatic print_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task automatic watch(input int n);
    n_rd = 0; n_wr = 0; n_busy = 0; n_err = 0;
    repeat (n)
    begin
      n_rd += (rd === 1'b1);
      n_wr += (wr === 1'b1);
      n_busy += (burst_active === 1'b1);
      n_err += (cmd_err === 1'b1);
      @(negedge sys_clk);
    end
  endtask
  task automatic check_defaults;
    `CHK({mr_three, mr_four, mr_five}, 54'h0)
    `CHK({init_done, bank_count}, 6'h10)
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check_defaults();
    host_u.issue(SDCI_CMD_RD, 2'h0, 2'h0, 18'h00010);
    watch(8);
    `CHK({n_err, n_rd}, {32'd1, 32'd0})
    host_u.init_seq(ok);
    `CHK(ok, 1'b1)
    `CHK({mr_three, mr_four, mr_five}, {18'h8, 18'h2040, 18'h5})
    foreach (rows[i])
    begin
      r = rows[i];
      x16_mode = r.x16;
      repeat (3) @(negedge sys_clk);
      is_rd = (r.cmd == SDCI_CMD_RD) || (r.cmd == SDCI_CMD_RDA);
      is_wr = (r.cmd == SDCI_CMD_WR) || (r.cmd == SDCI_CMD_WRA);
      if (r.cmd == SDCI_CMD_ACT)
      begin
        e_grp = r.x16 ? {1'b0, r.grp[0]} : r.grp;
        e_bnk = r.bnk;
        e_row = r.adr;
      end
      else
      begin
        e_col = r.adr;
        e_ap = r.adr[10];
        e_chop = ~r.adr[12];
      end
      host_u.issue(r.cmd, r.grp, r.bnk, r.adr);
      watch(8);
      `CHK({n_rd, n_wr}, {int'(is_rd), int'(is_wr)})
      `CHK(n_busy, (is_rd || is_wr) ? (e_chop ? 3 : 5) : 0)
      `CHK({act_group, act_bank, act_row}, {e_grp, e_bnk, e_row})
      `CHK({col, auto_pre, chop}, {e_col, e_ap, e_chop})
      `CHK(bank_count, r.x16 ? 5'h08 : 5'h10)
    end
    host_u.issue(SDCI_CMD_RD, 2'h0, 2'h0, 18'h01001);
    host_u.issue(SDCI_CMD_WR, 2'h0, 2'h0, 18'h02002);
    watch(8);
    `CHK({n_wr, col}, {32'd0, 18'h01001})
    host_u.issue(SDCI_CMD_MRS, 2'h0, 2'h0, 18'h00000);
    host_u.issue(SDCI_CMD_RD, 2'h0, 2'h0, 18'h00000);
    watch(8);
    `CHK(n_busy, 5)
    `CHK({chop, n_rd}, {1'b0, 32'd1})
    host_u.issue(SDCI_CMD_BAD, 2'h0, 2'h0, 18'h00000);
    watch(4);
    `CHK({n_err, n_rd}, {32'd1, 32'd0})
    scan_en = 1'b1;
    repeat (5) @(negedge sys_clk);
    host_u.issue(SDCI_CMD_RD, 2'h0, 2'h0, 18'h00020);
    watch(8);
    `CHK({n_err, n_rd}, {32'd1, 32'd1})
    scan_en = 1'b0;
    host_u.hold_low();
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    x16_mode = 1'b0;
    @(negedge sys_clk);
    check_defaults();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
